//--- inc/pbm_pkg.sv
// Constants and types for the Port B width and byte-order converter
package pbm_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Data path geometry
  localparam int LW = 36;
  localparam int LANE = 9;
  localparam int NLANE = 4;

  ////////////////////////////////////////////////////////////////////////////
  // APB register map (byte addresses)
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_STATUS = 12'h004;
  localparam logic [11:0] OFS_COUNT = 12'h008;

  // Control register fields and reset value
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_CLR_BIT = 1;
  localparam logic [1:0] CTRL_RST = 2'h1;

  // Status register fields
  localparam int ST_CFG_VALID = 0;
  localparam int ST_WIDTH = 1;
  localparam int ST_SIZE = 2;
  localparam int ST_ORDER = 3;
  localparam int ST_RD_IDX = 4;
  localparam int ST_WR_IDX = 6;
  localparam int ST_FLAG = 8;

  ////////////////////////////////////////////////////////////////////////////
  // Synchronised pin vector: positions and reset value
  localparam int NPIN = 6;
  localparam int PIN_WIDTH = 0;
  localparam int PIN_SIZE = 1;
  localparam int PIN_ORDER = 2;
  localparam int PIN_FCLR_AB = 3;
  localparam int PIN_FCLR_BA = 4;
  localparam int PIN_DCLR_AB = 5;
  localparam logic [NPIN-1:0] SYNC_RST = 6'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Piece sequencing and flag timing
  localparam logic [1:0] LAST_LONG = 2'h0;
  localparam logic [1:0] LAST_WORD = 2'h1;
  localparam logic [1:0] LAST_BYTE = 2'h3;
  localparam logic [1:0] EMPTY_DLY_STD = 2'h2;
  localparam logic [1:0] EMPTY_DLY_FT = 2'h1;

  typedef enum logic [1:0] {PBM_LONG, PBM_WORD, PBM_BYTE} pbm_mode_t;

endpackage

//--- rtl/pbm_match.sv
// Port B bus-matching converter between 36-bit queues and a 9/18/36-bit port
//
// Register access over APB and the register addresses were chosen for this implementation.
`timescale 1ns/1ps

module pbm_match
  import pbm_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Configuration and clear pins
  input wire logic width_match_select,
  input wire logic size_select,
  input wire logic order_or_fallthrough_select,
  input wire logic full_clear_a_to_b_n,
  input wire logic full_clear_b_to_a_n,
  input wire logic data_clear_a_to_b_n,
  // Port B transfer request
  input wire logic port_b_sel,
  input wire logic port_b_write,
  input wire logic port_b_mailbox_select,
  input wire logic [LW-1:0] port_b_din,
  output logic [LW-1:0] port_b_dout,
  output logic port_b_empty_flag,
  // A-to-B queue read side
  input wire logic [LW-1:0] rd_data,
  input wire logic rd_avail,
  output logic rd_take,
  // B-to-A queue write side
  input wire logic wr_room,
  output logic [LW-1:0] wr_data,
  output logic wr_push,
  // Mailbox bypass
  input wire logic [LW-1:0] mail_rd_data,
  output logic [LW-1:0] mail_wr_data,
  output logic mail_wr
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisation and configuration latch

  logic [NPIN-1:0] pins_s;
  logic mrs_both_q;
  logic wmatch_q;
  logic size_q;
  logic order_q;
  logic cfg_valid_q;
  logic [1:0] ctrl_q;
  logic soft_clr_q;

  pbm_sync3 u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pin_in({data_clear_a_to_b_n, full_clear_b_to_a_n, full_clear_a_to_b_n,
             order_or_fallthrough_select, size_select, width_match_select}),
    .pin_out(pins_s)
  );

  wire mrs_both = pins_s[PIN_FCLR_AB] & pins_s[PIN_FCLR_BA];
  wire cfg_latch = mrs_both & ~mrs_both_q;
  wire clr_full = ~mrs_both;
  wire clr_act = clr_full | ~pins_s[PIN_DCLR_AB] | soft_clr_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mrs_both_q <= 1'b0;
      wmatch_q <= 1'b0;
      size_q <= 1'b0;
      order_q <= 1'b0;
      cfg_valid_q <= 1'b0;
    end else begin
      mrs_both_q <= mrs_both;
      if (cfg_latch) begin
        wmatch_q <= pins_s[PIN_WIDTH];
        size_q <= pins_s[PIN_SIZE];
        order_q <= pins_s[PIN_ORDER];
        cfg_valid_q <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode decode and request qualification

  pbm_mode_t mode;
  logic [1:0] last_idx;
  assign mode = !wmatch_q ? PBM_LONG : (!size_q ? PBM_WORD : PBM_BYTE);
  assign last_idx = (mode == PBM_LONG) ? LAST_LONG : ((mode == PBM_WORD) ? LAST_WORD : LAST_BYTE);

  logic [1:0] rd_idx_q;
  logic [1:0] wr_idx_q;
  logic [LW-1:0] rd_hold_q;
  logic [LW-1:0] wr_asm_q;

  wire q_en = ctrl_q[CTRL_EN_BIT] & cfg_valid_q & ~clr_act;
  wire rd_req = port_b_sel & ~port_b_write & ~port_b_mailbox_select & q_en;
  wire wr_req = port_b_sel & port_b_write & ~port_b_mailbox_select & q_en;
  wire rd_first = (rd_idx_q == 2'h0);
  wire rd_accept = rd_req & (~rd_first | rd_avail);
  wire wr_last = (wr_idx_q == last_idx);
  wire wr_accept = wr_req & (~wr_last | wr_room);
  wire mbx_rd = port_b_sel & ~port_b_write & port_b_mailbox_select;
  wire mbx_wr = port_b_sel & port_b_write & port_b_mailbox_select;

  ////////////////////////////////////////////////////////////////////////////
  // Read disassembly

  wire [LW-1:0] rd_word = rd_first ? rd_data : rd_hold_q;
  wire [1:0] rd_lane = order_q ? ~rd_idx_q : rd_idx_q;
  wire rd_half = order_q ? ~rd_idx_q[0] : rd_idx_q[0];
  wire [LANE-1:0] rd_lanes [NLANE];
  logic [LW-1:0] rd_piece;

  ////////////////////////////////////////////////////////////////////////////
  // Write assembly, one lane per generate step

  wire [1:0] wr_lane = order_q ? ~wr_idx_q : wr_idx_q;
  wire wr_half = order_q ? ~wr_idx_q[0] : wr_idx_q[0];
  logic [LW-1:0] wr_merge;
  logic [LW-1:0] lane_mask;

  for (genvar g = 0; g < NLANE; g++) begin : g_lane
    assign rd_lanes[g] = rd_word[g*LANE +: LANE];
    wire hit = (mode == PBM_LONG) | ((mode == PBM_BYTE) & (wr_lane == 2'(g)))
               | ((mode == PBM_WORD) & (wr_half == 1'(g / 2)));
    wire [LANE-1:0] src = (mode == PBM_LONG) ? port_b_din[g*LANE +: LANE]
                        : (mode == PBM_BYTE) ? port_b_din[LANE-1:0]
                        : port_b_din[(g % 2)*LANE +: LANE];
    assign wr_merge[g*LANE +: LANE] = hit ? src : wr_asm_q[g*LANE +: LANE];
    assign lane_mask[g*LANE +: LANE] = {LANE{(mode == PBM_LONG) | (g == 0)
                                        | ((mode == PBM_WORD) & (g == 1))}};
  end

  // Lanes above the selected width are driven as zero
  always_comb begin
    case (mode)
      PBM_LONG: rd_piece = rd_word;
      PBM_WORD: rd_piece = {18'h0, rd_half ? rd_word[35:18] : rd_word[17:0]};
      PBM_BYTE: rd_piece = {27'h0, rd_lanes[rd_lane]};
      default: rd_piece = rd_word;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Piece counters, holding registers and transfer outputs

  logic [15:0] push_cnt_q;
  logic [15:0] fetch_cnt_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_idx_q <= 2'h0;
      wr_idx_q <= 2'h0;
      rd_hold_q <= 36'h0;
      wr_asm_q <= 36'h0;
    end else if (clr_act) begin
      rd_idx_q <= 2'h0;
      wr_idx_q <= 2'h0;
      rd_hold_q <= 36'h0;
      wr_asm_q <= 36'h0;
    end else begin
      if (rd_accept) begin
        rd_idx_q <= (rd_idx_q == last_idx) ? 2'h0 : rd_idx_q + 2'h1;
        if (rd_first) begin
          rd_hold_q <= rd_data;
        end
      end
      if (wr_accept) begin
        wr_idx_q <= wr_last ? 2'h0 : wr_idx_q + 2'h1;
        wr_asm_q <= wr_merge;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_b_dout <= 36'h0;
      rd_take <= 1'b0;
      wr_data <= 36'h0;
      wr_push <= 1'b0;
      mail_wr_data <= 36'h0;
      mail_wr <= 1'b0;
    end else begin
      rd_take <= rd_accept & rd_first;
      wr_push <= wr_accept & wr_last;
      mail_wr <= mbx_wr;
      if (rd_accept) begin
        port_b_dout <= rd_piece;
      end else if (mbx_rd) begin
        port_b_dout <= mail_rd_data & lane_mask;
      end
      if (wr_accept & wr_last) begin
        wr_data <= wr_merge;
      end
      if (mbx_wr) begin
        mail_wr_data <= port_b_din & lane_mask;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      push_cnt_q <= 16'h0;
      fetch_cnt_q <= 16'h0;
    end else if (clr_full) begin
      push_cnt_q <= 16'h0;
      fetch_cnt_q <= 16'h0;
    end else begin
      push_cnt_q <= push_cnt_q + 16'(wr_accept & wr_last);
      fetch_cnt_q <= fetch_cnt_q + 16'(rd_accept & rd_first);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Empty flag: forced low after the first clear cycle in fall-through timing, after the second in standard timing

  logic [1:0] clr_cnt_q;
  wire fall_through_timing = pins_s[PIN_ORDER];
  wire [1:0] empty_dly = fall_through_timing ? EMPTY_DLY_FT : EMPTY_DLY_STD;
  wire [1:0] clr_cnt_d = (clr_cnt_q == 2'h3) ? clr_cnt_q : clr_cnt_q + 2'h1;
  wire [1:0] rd_idx_nx = rd_accept ? ((rd_idx_q == last_idx) ? 2'h0 : rd_idx_q + 2'h1) : rd_idx_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clr_cnt_q <= 2'h0;
      port_b_empty_flag <= 1'b0;
    end else if (clr_act) begin
      clr_cnt_q <= clr_cnt_d;
      if (clr_cnt_d >= empty_dly) begin
        port_b_empty_flag <= 1'b0;
      end
    end else begin
      clr_cnt_q <= 2'h0;
      port_b_empty_flag <= q_en & ((rd_idx_nx != 2'h0) | (rd_avail & ~(rd_accept & rd_first)));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB slave: one wait state, data and error valid with pready

  wire apb_acc = psel & penable & ~pready;
  wire apb_done = psel & penable & pready;
  wire hit_ctrl = (paddr == OFS_CTRL);
  wire hit_status = (paddr == OFS_STATUS);
  wire hit_count = (paddr == OFS_COUNT);
  wire hit_any = hit_ctrl | hit_status | hit_count;
  wire ctrl_wr = apb_done & pwrite & hit_ctrl;

  logic [31:0] status_word;
  assign status_word = {23'h0, port_b_empty_flag, wr_idx_q, rd_idx_q, order_q, size_q, wmatch_q, cfg_valid_q};
  wire [31:0] rd_mux = hit_ctrl ? {30'h0, ctrl_q} : hit_status ? status_word
                     : hit_count ? {push_cnt_q, fetch_cnt_q} : 32'h0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0;
      pslverr <= 1'b0;
      ctrl_q <= CTRL_RST;
      soft_clr_q <= 1'b0;
    end else begin
      pready <= apb_acc;
      pslverr <= apb_acc & ~hit_any;
      prdata <= (apb_acc & ~pwrite) ? rd_mux : 32'h0;
      soft_clr_q <= ctrl_wr & pwdata[CTRL_CLR_BIT];
      if (ctrl_wr) begin
        ctrl_q <= {1'b0, pwdata[CTRL_EN_BIT]};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_LONG_PASS: assert property (
    rd_accept && mode == PBM_LONG |=> port_b_dout == $past(rd_data))
    else $error("long read did not pass the word through");

  AST_FETCH_FIRST: assert property (
    rd_take |-> $past(rd_idx_q) == 2'h0 && $past(rd_avail))
    else $error("queue fetched in mid long word");

  AST_COMMIT_LAST: assert property (
    wr_push |-> $past(wr_accept) && $past(wr_idx_q) == $past(last_idx))
    else $error("long word committed before its last piece");

  AST_LONG_WRITE: assert property (
    wr_accept && mode == PBM_LONG |=> wr_push && wr_data == $past(port_b_din))
    else $error("long write did not keep lanes");

  AST_WORD_WRITE: assert property (
    wr_accept && mode == PBM_WORD && wr_idx_q == 2'h0 && !clr_act
    |=> wr_asm_q[17:0] == (order_q ? $past(wr_asm_q[17:0]) : $past(port_b_din[17:0])))
    else $error("first word written to wrong half");

  AST_BYTE_WRITE: assert property (
    wr_accept && mode == PBM_BYTE && order_q && wr_idx_q == 2'h0
    |=> wr_asm_q[35:27] == $past(port_b_din[8:0]))
    else $error("big-endian first byte not in top lane");

  AST_WORD_READ: assert property (
    rd_accept && mode == PBM_WORD && rd_first
    |=> port_b_dout[17:0] == (order_q ? $past(rd_data[35:18]) : $past(rd_data[17:0])))
    else $error("first word read from wrong half");

  AST_ORDER_HOLD: assert property (
    !cfg_latch |=> $stable(order_q) && $stable(wmatch_q) && $stable(size_q))
    else $error("configuration changed outside full clear release");

  AST_FLAG_FT: assert property (
    $rose(clr_act) && fall_through_timing |=> !port_b_empty_flag)
    else $error("fall-through empty flag late");

  AST_FLAG_STD: assert property (
    $rose(clr_act) && !fall_through_timing ##1 clr_act && !fall_through_timing |=> !port_b_empty_flag)
    else $error("standard empty flag late");

  AST_MBX_BYPASS: assert property (
    mbx_wr && !clr_act |=> mail_wr && wr_idx_q == $past(wr_idx_q) && !wr_push)
    else $error("mailbox write disturbed queue path");

  AST_CLEAR: assert property (
    clr_act |=> rd_idx_q == 2'h0 && wr_idx_q == 2'h0 && !rd_take && !wr_push)
    else $error("clear left piece state");

  AST_IDX_IDLE: assert property (
    !rd_accept && !clr_act |=> $stable(rd_idx_q))
    else $error("read piece counter moved without a transfer");

endmodule

//--- rtl/pbm_sync3.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module pbm_sync3
  import pbm_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Pins and filtered levels
  input wire logic [NPIN-1:0] pin_in,
  output logic [NPIN-1:0] pin_out
);

  logic [NPIN-1:0] s1_q;
  logic [NPIN-1:0] s2_q;
  logic [NPIN-1:0] s3_q;

  for (genvar g = 0; g < NPIN; g++) begin : g_bit
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        s1_q[g] <= SYNC_RST[g];
        s2_q[g] <= SYNC_RST[g];
        s3_q[g] <= SYNC_RST[g];
        pin_out[g] <= SYNC_RST[g];
      end else begin
        s1_q[g] <= pin_in[g];
        s2_q[g] <= s1_q[g];
        s3_q[g] <= s2_q[g];
        // A change counts once stages two and three agree
        if (s2_q[g] == s3_q[g]) begin
          pin_out[g] <= s3_q[g];
        end
      end
    end
  end

endmodule

//--- verif/pbm_host.sv
// Host-side model that drives the narrow Port B and the configuration and clear pins
`timescale 1ns/1ps
module pbm_host
  import pbm_pkg::*;
(
  // Clock
  input wire logic pclk,
  // Port B request and read data
  output logic sel,
  output logic wr,
  output logic mb,
  output logic [LW-1:0] din,
  input wire logic [LW-1:0] dout,
  // Configuration and clear pins
  output logic wm,
  output logic sz,
  output logic bo,
  output logic fc_ab_n,
  output logic fc_ba_n,
  output logic dc_ab_n
);
  initial begin
    sel = 1'b0;
    wr = 1'b0;
    mb = 1'b0;
    din = '0;
    wm = 1'b0;
    sz = 1'b0;
    bo = 1'b0;
    fc_ab_n = 1'b1;
    fc_ba_n = 1'b1;
    dc_ab_n = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // One transfer held for one edge; released data shows its inverse
  task automatic xfer(input logic w, input logic m, input logic [LW-1:0] d, output logic [LW-1:0] q);
    @(posedge pclk);
    sel <= 1'b1;
    wr <= w;
    mb <= m;
    din <= d;
    @(posedge pclk);
    sel <= 1'b0;
    din <= ~d;
    @(negedge pclk);
    q = dout;
  endtask

  // Widths and byte order change only while both full clears are low
  task automatic full_clear(input logic w, input logic s, input logic o);
    @(posedge pclk);
    dc_ab_n <= 1'b1;
    fc_ab_n <= 1'b0;
    fc_ba_n <= 1'b0;
    @(posedge pclk);
    wm <= w;
    sz <= s;
    bo <= o;
    repeat (4) @(posedge pclk);
    fc_ab_n <= 1'b1;
    fc_ba_n <= 1'b1;
  endtask

  task automatic data_clear();
    @(posedge pclk);
    dc_ab_n <= 1'b0;
    repeat (5) @(posedge pclk);
    dc_ab_n <= 1'b1;
  endtask
endmodule

//--- verif/port_b_bus_matching_tb.sv
// Self-checking bench for the Port B width and byte-order converter
`timescale 1ns/1ps
module port_b_bus_matching_tb;
  import pbm_pkg::*;
  localparam logic [LW-1:0] LWV = {9'h1a1, 9'h0b2, 9'h1c3, 9'h0d4};
  localparam logic [LW-1:0] LW2 = {9'h111, 9'h022, 9'h133, 9'h044};
  localparam logic [LW-1:0] MRD = 36'h5a5a5a5a5;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, perr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, prd;
  logic wm, sz, bo, fc_ab_n, fc_ba_n, dc_ab_n, sel, wr, mb;
  logic [LW-1:0] din, dout, rd_data, wr_data, mail_wr_data, mail_rd_data;
  logic rd_avail, rd_take, wr_room, wr_push, mail_wr, efl;
  logic [LW-1:0] aq [4];
  logic [1:0] ah, at;
  int fail_count, n_compared, cyc;

  pbm_match i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .width_match_select(wm), .size_select(sz), .order_or_fallthrough_select(bo),
    .full_clear_a_to_b_n(fc_ab_n), .full_clear_b_to_a_n(fc_ba_n), .data_clear_a_to_b_n(dc_ab_n),
    .port_b_sel(sel), .port_b_write(wr), .port_b_mailbox_select(mb), .port_b_din(din),
    .port_b_dout(dout), .port_b_empty_flag(efl), .rd_data(rd_data), .rd_avail(rd_avail),
    .rd_take(rd_take), .wr_room(wr_room), .wr_data(wr_data), .wr_push(wr_push),
    .mail_rd_data(mail_rd_data), .mail_wr_data(mail_wr_data), .mail_wr(mail_wr));

  pbm_host i_host (.pclk(pclk), .sel(sel), .wr(wr), .mb(mb), .din(din), .dout(dout), .wm(wm),
    .sz(sz), .bo(bo), .fc_ab_n(fc_ab_n), .fc_ba_n(fc_ba_n), .dc_ab_n(dc_ab_n));

  ////////////////////////////////////////////////////////////////////////////
  // A-to-B queue model and run limit
  assign rd_avail = ah != at;
  assign rd_data = aq[ah];
  always @(posedge pclk) begin
    if (rd_take) begin
      ah <= ah + 2'h1;
    end
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      end_sim();
    end
  end

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic [LW-1:0] msk(input int np);
    return np == 1 ? {LW{1'b1}} : (np == 2 ? 36'h00003ffff : 36'h0000001ff);
  endfunction

  function automatic logic [LW-1:0] pc(input logic [LW-1:0] v, input int np, input int k, input logic o);
    return (v >> ((LW / np) * (o ? np - 1 - k : k))) & msk(np);
  endfunction

  task automatic chk(input string n, input logic [LW-1:0] g, input logic [LW-1:0] e);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // pready ends this wait; the run limit ends it if pready never rises
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    prd = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_regs();
    apb(1'b0, OFS_CTRL, 32'h0);
    chk("ctrl_reset", prd, {30'h0, CTRL_RST});
    apb(1'b1, OFS_CTRL, 32'h0);
    apb(1'b0, OFS_CTRL, 32'h0);
    chk("ctrl_rw", prd, 36'h0);
    apb(1'b1, OFS_CTRL, 32'h1);
    apb(1'b0, 12'h00c, 32'h0);
    chk("slverr", perr, 1'b1);
    $display("test registers done");
  endtask

  task automatic t_mode(input logic w, input logic s, input logic o);
    int np;
    logic [LW-1:0] m, q;
    np = w ? (s ? 4 : 2) : 1;
    m = msk(np);
    i_host.full_clear(w, s, o);
    repeat (6) @(posedge pclk);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk("status", prd[8:0], {5'h00, o, s, w, 1'b1});
    i_host.bo <= ~o;
    aq[at] <= LWV;
    at <= at + 2'h1;
    repeat (2) @(negedge pclk);
    chk("flag_avail", efl, 1'b1);
    for (int k = 0; k < np; k++) begin
      i_host.xfer(1'b0, 1'b0, '0, q);
      chk("rd_piece", q & m, pc(LWV, np, k, o));
    end
    for (int k = 0; k < np; k++) begin
      if (k == 1) begin
        i_host.xfer(1'b1, 1'b1, LWV, q);
        chk("mail_wr", mail_wr, 1'b1);
        chk("mail_data", mail_wr_data, LWV & m);
      end
      i_host.xfer(1'b1, 1'b0, ~m | pc(LWV, np, k, o), q);
      chk("push", wr_push, k == np - 1);
    end
    chk("wr_long", wr_data, LWV);
    chk("flag_empty", efl, 1'b0);
    i_host.xfer(1'b0, 1'b1, '0, q);
    chk("mail_rd", q & m, MRD & m);
    apb(1'b0, OFS_COUNT, 32'h0);
    chk("count", prd, 32'h00010001);
    $display("test mode %0d%0d%0d done", w, s, o);
  endtask

  task automatic t_clear(input logic ft);
    logic [LW-1:0] q;
    i_host.bo <= ft;
    aq[at] <= LW2;
    at <= at + 2'h1;
    i_host.xfer(1'b1, 1'b0, 36'h0000000aa, q);
    i_host.xfer(1'b1, 1'b0, 36'h0000000bb, q);
    chk("clr_flag_set", efl, 1'b1);
    i_host.data_clear();
    @(negedge pclk);
    chk("clr_flag_early", efl, !ft);
    @(negedge pclk);
    chk("clr_flag_low", efl, 1'b0);
    repeat (6) @(posedge pclk);
    for (int k = 0; k < 4; k++) begin
      i_host.xfer(1'b1, 1'b0, pc(LW2, 4, k, 1'b0), q);
    end
    chk("clr_push", wr_push, 1'b1);
    chk("clr_long", wr_data, LW2);
    // Soft clear in mid assembly restarts at the first piece
    i_host.xfer(1'b1, 1'b0, 36'h0000000cc, q);
    apb(1'b1, OFS_CTRL, 32'h3);
    apb(1'b0, OFS_CTRL, 32'h0);
    chk("ctrl_clr_rd", prd, 36'h1);
    for (int k = 0; k < 4; k++) begin
      i_host.xfer(1'b1, 1'b0, pc(LW2, 4, k, 1'b0), q);
    end
    chk("soft_push", wr_push, 1'b1);
    chk("soft_long", wr_data, LW2);
    $display("test data clear %0d done", ft);
  endtask

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    wr_room = 1'b1;
    mail_rd_data = MRD;
    ah = 2'h0;
    at = 2'h0;
    fail_count = 0;
    n_compared = 0;
    cyc = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_mode(1'b0, 1'b1, 1'b1);
    t_mode(1'b1, 1'b0, 1'b1);
    t_mode(1'b1, 1'b0, 1'b0);
    t_mode(1'b1, 1'b1, 1'b1);
    t_mode(1'b1, 1'b1, 1'b0);
    t_clear(1'b1);
    t_clear(1'b0);
    end_sim();
  end
endmodule
